//--- common/cad_pkg.sv
// Package for the add and logic datapath slice
package cad_pkg;

  // Bus and word widths
  localparam int unsigned WORD_W = 32;
  localparam int unsigned IMM_W  = 16;
  localparam int unsigned REG_W  = 5;

  // Fixed vector addresses
  localparam logic [31:0] VEC_RESET   = 32'h0000_0000;
  localparam logic [31:0] VEC_USR_EXC = 32'h0000_0008;
  localparam logic [31:0] VEC_IRQ     = 32'h0000_0010;
  localparam logic [31:0] VEC_HW_EXC  = 32'h0000_0020;
  localparam logic [31:0] PC_STEP     = 32'h0000_0004;

  // Instruction field positions (bit 0 is the most significant bit)
  localparam int unsigned POS_DST = 6;
  localparam int unsigned POS_SA  = 11;
  localparam int unsigned POS_SB  = 16;
  localparam int unsigned POS_KEEP  = 3;
  localparam int unsigned POS_CIN   = 4;

  // Major opcodes, upper six bits
  localparam logic [5:0] OP_ADD   = 6'h00;
  localparam logic [5:0] OP_ADDI  = 6'h08;
  localparam logic [5:0] OP_AND   = 6'h21;
  localparam logic [5:0] OP_ANDN  = 6'h23;
  localparam logic [5:0] OP_ANDI  = 6'h29;
  localparam logic [5:0] OP_ANDNI = 6'h2b;
  localparam logic [5:0] OP_IMM   = 6'h2c;
  localparam logic [5:0] OP_ADD_MASK = 6'h38;

  // Register offsets on the AHB-Lite slave
  localparam logic [7:0] OFF_INSTR  = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h0c;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_RF_SEL = 8'h14;
  localparam logic [7:0] OFF_RF_DAT = 8'h18;

  // Control bits
  localparam int unsigned CTRL_USR = 0;
  localparam int unsigned CTRL_IRQ = 1;
  localparam int unsigned CTRL_HW  = 2;
  localparam int unsigned CTRL_CY  = 3;

  typedef enum logic [2:0] {
    CAD_NOP, CAD_ADD, CAD_AND, CAD_ANDN, CAD_PFX
  } cad_op_t;

endpackage

//--- logic/cad_decode.sv
// Instruction decoder for the add and logic datapath
`timescale 1ns/1ps
module cad_decode
  import cad_pkg::*;
(
  input  wire logic [31:0] instr,
  input  wire logic        pfx_valid,
  input  wire logic [15:0] pfx_high,
  output cad_op_t          op,
  output logic [4:0]       dst,
  output logic [4:0]       src_a,
  output logic [4:0]       src_b,
  output logic             use_imm,
  output logic [31:0]      imm_val,
  output logic             keep_cy,
  output logic             use_cin
);

  logic [5:0] opc;

  always_comb begin
    opc     = instr[31:26];
    // Field bit n counts from the top of the word
    dst     = instr[31-POS_DST -: REG_W];  // see [RULE2]
    src_a   = instr[31-POS_SA -: REG_W];   // see [RULE2]
    src_b   = instr[31-POS_SB -: REG_W];   // see [RULE2]
    use_imm = opc[3];
    // Only opcode bits are decoded, never the status flag, see [RULE10]
    keep_cy = opc[5-POS_KEEP];  // see [RULE5]
    use_cin = opc[5-POS_CIN];   // see [RULE5]
    if (pfx_valid) begin
      imm_val = {pfx_high, instr[15:0]};  // see [RULE9]
    end else begin
      imm_val = {{16{instr[15]}}, instr[15:0]};  // see [RULE3] see [RULE9]
    end
    op = CAD_NOP;
    if ((opc & OP_ADD_MASK) == OP_ADD || (opc & OP_ADD_MASK) == OP_ADDI) begin
      op = CAD_ADD;
    end else if (opc == OP_AND || opc == OP_ANDI) begin
      op = CAD_AND;
    end else if (opc == OP_ANDN || opc == OP_ANDNI) begin
      op = CAD_ANDN;
    end else if (opc == OP_IMM) begin
      op = CAD_PFX;
    end
  end

endmodule

//--- logic/cad_core.sv
// Add and logic datapath with vector redirection and AHB-Lite access
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// [RULE1] Reset fetches at 0x0; user exception 0x8, interrupt 0x10, hardware exception 0x20.
// [RULE2] Register form: 6-bit opcode, destination at bit 6, sources at 11 and 16.
// [RULE3] Literal form: opcode, destination, one source, 16-bit literal in bits 16 to 31.
// [RULE4] Register add writes 32-bit sum of both sources to destination.
// [RULE5] Bit 3 selects carry keep, bit 4 carry input, independently.
// [RULE6] Keep set leaves carry flag; clear stores adder carry out.
// [RULE7] Carry input set adds current carry flag; clear gives plain sum.
// [RULE8] Add literal adds sign-extended literal with the same carry options.
// [RULE9] Literal is sign-extended unless preceded by prefix giving full 32 bits.
// [RULE10] Opcode carry-input bit and status carry flag are never confused.
// [RULE11] Register AND writes bitwise AND of sources, carry untouched.
// [RULE12] AND literal writes source AND sign-extended literal.
// [RULE13] AND-NOT writes first source AND complement of second source.
// [RULE14] AND-NOT literal writes source AND complement of extended literal.
// [RULE15] Each operation completes in one cycle, no stall.
// [RULE16] Vector redirection loads the fixed address, discarding younger instructions.
module cad_core
  import cad_pkg::*;
#(
  parameter int unsigned NUM_REGS = 32
)(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  ////////////////////////////////////////////////////////////////////
  // Bus address phase capture

  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [7:0]  addr_q;
  logic        take;

  assign take      = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      addr_q    <= haddr[7:0];
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic wr_instr;
  logic wr_ctrl;
  logic wr_sel;
  logic wr_dat;
  logic wr_pc;

  assign wr_instr = wr_pend_q && hit(addr_q, OFF_INSTR);
  assign wr_ctrl  = wr_pend_q && hit(addr_q, OFF_CTRL);
  assign wr_sel   = wr_pend_q && hit(addr_q, OFF_RF_SEL);
  assign wr_dat   = wr_pend_q && hit(addr_q, OFF_RF_DAT);
  assign wr_pc    = wr_pend_q && hit(addr_q, OFF_PC);

  ////////////////////////////////////////////////////////////////////
  // Decode

  cad_op_t     op;
  logic [4:0]  dst;
  logic [4:0]  src_a;
  logic [4:0]  src_b;
  logic        use_imm;
  logic [31:0] imm_val;
  logic        keep_cy;
  logic        use_cin;
  logic        pfx_valid_q;
  logic [15:0] pfx_high_q;

  cad_decode u_dec (
    .instr     (hwdata),
    .pfx_valid (pfx_valid_q),
    .pfx_high  (pfx_high_q),
    .op        (op),
    .dst       (dst),
    .src_a     (src_a),
    .src_b     (src_b),
    .use_imm   (use_imm),
    .imm_val   (imm_val),
    .keep_cy   (keep_cy),
    .use_cin   (use_cin)
  );

  ////////////////////////////////////////////////////////////////////
  // Register file and execute

  logic [31:0] regs_q [NUM_REGS];
  logic [31:0] first_source_register;
  logic [31:0] second_source_register;
  logic [31:0] opnd_b;
  logic [32:0] sum;
  logic [31:0] result;
  logic        status_carry_flag;
  logic [31:0] machine_status_word;
  logic        redirect;
  logic        exec;

  assign first_source_register  = regs_q[src_a];
  assign second_source_register = regs_q[src_b];
  assign opnd_b = use_imm ? imm_val : second_source_register;  // see [RULE8] see [RULE12]
  assign redirect = wr_ctrl && (hwdata[CTRL_USR] || hwdata[CTRL_IRQ] || hwdata[CTRL_HW]);
  assign exec = wr_instr && !redirect;

  always_comb begin
    sum    = {1'b0, first_source_register} + {1'b0, opnd_b};  // see [RULE4] see [RULE8]
    if (use_cin) begin
      sum = sum + {32'h0000_0000, status_carry_flag};  // see [RULE7]
    end
    result = 32'h0000_0000;
    unique case (op)
      CAD_ADD:  result = sum[31:0];                                 // see [RULE4]
      CAD_AND:  result = first_source_register & opnd_b;            // see [RULE11] see [RULE12]
      CAD_ANDN: result = first_source_register & ~opnd_b;           // see [RULE13] see [RULE14]
      CAD_NOP:  result = 32'h0000_0000;
      CAD_PFX:  result = 32'h0000_0000;
    endcase
  end

  logic [31:0] result_q;
  logic [4:0]  rf_sel_q;

  // Single-cycle write back, see [RULE15]
  always_ff @(posedge core_clk) begin
    if (exec && op != CAD_NOP && op != CAD_PFX && dst != 5'd0) begin
      regs_q[dst] <= result;
    end else if (wr_dat && rf_sel_q != 5'd0) begin
      regs_q[rf_sel_q] <= hwdata;
    end
    regs_q[0] <= 32'h0000_0000;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= 32'h0000_0000;
    end else if (exec) begin
      result_q <= result;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_sel_q <= 5'd0;
    end else if (wr_sel) begin
      rf_sel_q <= hwdata[4:0];
    end
  end

  // Carry flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_carry_flag <= 1'b0;
    end else if (exec && op == CAD_ADD && !keep_cy) begin
      status_carry_flag <= sum[32];  // see [RULE6]
    end else if (wr_ctrl && !redirect) begin
      status_carry_flag <= hwdata[CTRL_CY];
    end
  end

  assign machine_status_word = {29'h0, pfx_valid_q, 1'b0, status_carry_flag};

  // Prefix holds for exactly the next instruction
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pfx_valid_q <= 1'b0;
      pfx_high_q  <= 16'h0000;
    end else if (redirect) begin
      pfx_valid_q <= 1'b0;  // see [RULE16]
    end else if (exec) begin
      pfx_valid_q <= (op == CAD_PFX);  // see [RULE9]
      pfx_high_q  <= hwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Program counter and vectors

  logic [31:0] pc_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= VEC_RESET;  // see [RULE1]
    end else if (wr_ctrl && hwdata[CTRL_HW]) begin
      pc_q <= VEC_HW_EXC;  // see [RULE1] see [RULE16]
    end else if (wr_ctrl && hwdata[CTRL_IRQ]) begin
      pc_q <= VEC_IRQ;  // see [RULE1] see [RULE16]
    end else if (wr_ctrl && hwdata[CTRL_USR]) begin
      pc_q <= VEC_USR_EXC;  // see [RULE1] see [RULE16]
    end else if (wr_pc) begin
      pc_q <= hwdata;
    end else if (exec) begin
      pc_q <= pc_q + PC_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_pend_q) begin
      unique case (addr_q)
        OFF_STATUS: hrdata = machine_status_word;
        OFF_RESULT: hrdata = result_q;
        OFF_PC:     hrdata = pc_q;
        OFF_RF_SEL: hrdata = {27'h0, rf_sel_q};
        OFF_RF_DAT: hrdata = regs_q[rf_sel_q];
        default:    hrdata = 32'h0000_0000;
      endcase
    end
  end

endmodule

//--- sim/cad_core_assertions.sv
// Bus-side checker for the add and logic datapath
`timescale 1ns/1ps
module cad_core_assertions
  import cad_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp
);
  logic        dp_q, wr_q, cy_q, cyv_q, rz_q;
  logic [7:0]  a_q;
  logic [31:0] pc_q;
  wire         take = hsel & hready & (htrans == 2'h2);
  wire         rd = dp_q & ~wr_q;
  wire         wr = dp_q & wr_q;
  // Data phase tracking
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_q <= 1'b0;
      wr_q <= 1'b0;
      a_q  <= 8'h0;
    end else if (hready) begin
      dp_q <= take;
      wr_q <= hwrite;
      a_q  <= haddr[7:0];
    end
  end
  // Expected program counter and carry flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q  <= VEC_RESET;
      cy_q  <= 1'b0;
      cyv_q <= 1'b1;
      rz_q  <= 1'b1;
    end else if (wr) begin
      case (a_q)
        OFF_INSTR: begin
          pc_q <= pc_q + PC_STEP;
          rz_q <= 1'b0;
          if (hwdata[31:30] == 2'b00 && !hwdata[28] && !hwdata[26]) cyv_q <= 1'b0;
        end
        OFF_CTRL: begin
          if (hwdata[2]) pc_q <= VEC_HW_EXC;
          else if (hwdata[1]) pc_q <= VEC_IRQ;
          else if (hwdata[0]) pc_q <= VEC_USR_EXC;
          else begin
            cy_q  <= hwdata[3];
            cyv_q <= 1'b1;
          end
        end
        OFF_PC: pc_q <= hwdata;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rdy; take |-> hreadyout ##1 hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("stall");
  property p_ok; dp_q |-> !hresp; endproperty
  a_ok: assert property (p_ok) else $error("error response");
  property p_pc; rd && a_q == OFF_PC |-> hrdata == pc_q; endproperty
  a_pc: assert property (p_pc) else $error("pc");
  property p_cy; rd && a_q == OFF_STATUS && cyv_q |-> hrdata[0] == cy_q; endproperty
  a_cy: assert property (p_cy) else $error("carry");
  property p_rz; rd && a_q == OFF_RESULT && rz_q |-> hrdata == 32'h0; endproperty
  a_rz: assert property (p_rz) else $error("result");
  property p_st; rd && a_q == OFF_STATUS |-> hrdata[31:3] == 29'h0 && !hrdata[1]; endproperty
  a_st: assert property (p_st) else $error("status");
  property p_unm; rd && a_q[7:5] != 3'h0 |-> hrdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped");
  property p_idle; !dp_q |-> hrdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle data");
endmodule
bind cad_core cad_core_assertions cad_core_assertions_i (
  .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp));

//--- sim/cad_host_model.sv
// Bus master model for single word transfers
`timescale 1ns/1ps
module cad_host_model (
  input  wire logic        core_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Released address and data lines show the inverse of their last value
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
    hsel <= 1'b0;
    hwdata <= ~hwdata;
    haddr <= ~haddr;
  endtask
endmodule

//--- sim/test_cpu_add_and_logic_datapath.sv
// Self-checking bench for the add and logic datapath
`timescale 1ns/1ps
module test_cpu_add_and_logic_datapath
  import cad_pkg::*;
;
  logic        core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  int          fail_count, num_checks;
  logic [5:0]  lop [4] = '{OP_AND, OP_ANDN, OP_ANDI, OP_ANDNI};
  logic [2:0]  vc [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
  logic [31:0] vv [4] = '{VEC_USR_EXC, VEC_IRQ, VEC_HW_EXC, VEC_HW_EXC};
  cad_core cad_core_i (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  cad_host_model cad_host_model_i (.core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cad_host_model_i.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    cad_host_model_i.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic setr(input logic [4:0] n, input logic [31:0] v);
    wr(OFF_RF_SEL, {27'h0, n});
    wr(OFF_RF_DAT, v);
  endtask
  function automatic logic [31:0] ins(input logic [5:0] op, input logic [4:0] d,
                                      input logic [4:0] a, input logic [15:0] lo);
    return {op, d, a, lo};
  endfunction
  task automatic complete_run;
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    complete_run;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [32:0] s;
    fail_count = 0;
    num_checks = 0;
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(OFF_PC, VEC_RESET);
    rd(OFF_RESULT, 32'h0);
    setr(5'd1, 32'hffff_ffff);
    setr(5'd2, 32'h1);
    setr(5'd6, 32'h0f0f_5a5a);
    setr(5'd7, 32'hffff_8765);
    // Add family: every option, both forms, both flag values
    for (int i = 0; i < 16; i++) begin
      wr(OFF_CTRL, {28'h0, i[3], 3'h0});
      wr(OFF_INSTR, ins({2'b00, i[2], i[1], i[0], 1'b0}, 5'd3, i[2] ? 5'd2 : 5'd1,
                        i[2] ? 16'hffff : 16'h1000));
      s = 33'h0_ffff_ffff + 33'h1 + {32'h0, i[0] & i[3]};
      rd(OFF_RESULT, s[31:0]);
      rd(OFF_STATUS, {31'h0, i[1] ? i[3] : s[32]});
    end
    // Logic operations, carry held at one
    wr(OFF_CTRL, 32'h8);
    wr(OFF_RF_SEL, 32'h3);
    foreach (lop[k]) begin
      wr(OFF_INSTR, ins(lop[k], 5'd3, 5'd6, lop[k][3] ? 16'h8765 : 16'h3800));
      rd(OFF_RF_DAT, lop[k][1] ? 32'h0f0f_5a5a & ~32'hffff_8765
                                : 32'h0f0f_5a5a & 32'hffff_8765);
      rd(OFF_STATUS, 32'h1);
    end
    // Prefixed literal, result used by the very next instruction
    wr(OFF_INSTR, ins(OP_IMM, 5'd0, 5'd0, 16'h0000));
    wr(OFF_INSTR, ins(6'h0c, 5'd4, 5'd0, 16'h8000));
    wr(OFF_INSTR, ins(6'h0c, 5'd5, 5'd4, 16'h7000));
    rd(OFF_RESULT, 32'h0000_f000);
    foreach (vc[k]) begin
      wr(OFF_CTRL, {29'h0, vc[k]});
      rd(OFF_PC, vv[k]);
      wr(OFF_INSTR, 32'hffff_ffff);
      rd(OFF_PC, vv[k] + PC_STEP);
    end
    // Redirect drops a pending prefix
    wr(OFF_INSTR, ins(OP_IMM, 5'd0, 5'd0, 16'h1234));
    wr(OFF_CTRL, 32'h2);
    wr(OFF_INSTR, ins(6'h0c, 5'd5, 5'd0, 16'h8000));
    rd(OFF_RESULT, 32'hffff_8000);
    wr(OFF_PC, 32'h0000_0100);
    rd(OFF_PC, 32'h0000_0100);
    rd(8'h40, 32'h0);
    complete_run;
  end
endmodule
